// *** inc/timer8_regs.vh ***
// register map, field positions and reset values of the 8-bit timer
`ifndef TIMER8_REGS_VH
`define TIMER8_REGS_VH
`define ADDR_TIMER_CONTROL_A      8'h44
`define ADDR_TIMER_CONTROL_B      8'h45
`define ADDR_TIMER_COUNT_VALUE    8'h46
`define ADDR_COMPARE_VALUE_A      8'h47
`define ADDR_COMPARE_VALUE_B      8'h48
`define ADDR_TIMER_INTERRUPT_FLAGS 8'h35
`define ADDR_TIMER_INTERRUPT_MASK 8'h6e
`define RESET_BYTE                8'h00
`define BIT_FORCE_A               7
`define BIT_FORCE_B               6
`define BIT_WAVE_MODE_BIT2        3
`define BIT_COMPARE_B             2
`define BIT_COMPARE_A             1
`define BIT_OVERFLOW              0
`define COUNT_MAX                 8'hff
`define COUNT_BOTTOM              8'h00
`define PRESCALE_8                10'h007
`define PRESCALE_64               10'h03f
`define PRESCALE_256              10'h0ff
`define PRESCALE_1024             10'h3ff
`define WAVE_NORMAL               3'h0
`define WAVE_CTC                  3'h2
`define WAVE_FAST_TOP_A           3'h7
`define CLOCK_STOPPED             3'h0
`endif

// *** hw/timer8_control_and_interrupt_regs.v ***
// 8-bit timer/counter with control, compare, mask and flag registers
`timescale 1ns/1ps
`default_nettype none
`include "timer8_regs.vh"
module timer8_control_and_interrupt_regs (
   input  wire       ref_clk_in,
   input  wire       rst_in,
   input  wire [7:0] io_addr_in,
   input  wire [7:0] io_wdata_in,
   input  wire       io_write_in,
   input  wire       io_read_in,
   input  wire       external_count_pin_in,
   input  wire       vector_ack_a_in,
   input  wire       vector_ack_b_in,
   input  wire       vector_ack_ovf_in,
   output reg  [7:0] io_rdata_out,
   output reg        compare_a_pin_out,
   output reg        compare_b_pin_out,
   output reg        compare_a_irq_out,
   output reg        compare_b_irq_out,
   output reg        overflow_irq_out
);
   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [7:0] control_a;
   reg  [3:0] control_b;
   reg  [7:0] timer_count_value;
   reg  [7:0] compare_value_a;
   reg  [7:0] compare_value_b;
   reg  [2:0] timer_interrupt_mask;
   reg  [2:0] timer_interrupt_flags;
   reg  [9:0] prescaler;
   reg        pin_prev;
   reg        count_down;
   reg        block_match;
   // ----------------------------------------------------------------
   // field and address decode
   // ----------------------------------------------------------------
   wire [2:0] wave_mode_select;
   wire [2:0] clock_source_select;
   wire [1:0] compare_a_output_mode;
   wire [1:0] compare_b_output_mode;
   wire       wr_ctrl_a;
   wire       wr_ctrl_b;
   wire       wr_count;
   wire       wr_cmp_a;
   wire       wr_cmp_b;
   wire       wr_mask;
   wire       wr_flags;
   wire       non_pwm;
   wire       phase_mode;
   wire       top_is_a;
   wire [7:0] top_value;
   assign wave_mode_select      = {control_b[`BIT_WAVE_MODE_BIT2], control_a[1:0]};
   assign clock_source_select   = control_b[2:0];
   assign compare_a_output_mode = control_a[7:6];
   assign compare_b_output_mode = control_a[5:4];
   assign wr_ctrl_a = io_write_in && (io_addr_in == `ADDR_TIMER_CONTROL_A);
   assign wr_ctrl_b = io_write_in && (io_addr_in == `ADDR_TIMER_CONTROL_B);
   assign wr_count  = io_write_in && (io_addr_in == `ADDR_TIMER_COUNT_VALUE);
   assign wr_cmp_a  = io_write_in && (io_addr_in == `ADDR_COMPARE_VALUE_A);
   assign wr_cmp_b  = io_write_in && (io_addr_in == `ADDR_COMPARE_VALUE_B);
   assign wr_mask   = io_write_in && (io_addr_in == `ADDR_TIMER_INTERRUPT_MASK);
   assign wr_flags  = io_write_in && (io_addr_in == `ADDR_TIMER_INTERRUPT_FLAGS);
   // reserved codes 4 and 6 count as pwm, so stray strobes there stay inert
   assign non_pwm    = (wave_mode_select == `WAVE_NORMAL) || (wave_mode_select == `WAVE_CTC);
   assign phase_mode = (wave_mode_select[1:0] == 2'h1);
   assign top_is_a   = wave_mode_select[2] || (wave_mode_select == `WAVE_CTC);
   assign top_value  = top_is_a ? compare_value_a : `COUNT_MAX;
   // ----------------------------------------------------------------
   // timer clock selection
   // ----------------------------------------------------------------
   reg        tick;
   // pin sampled regardless of its direction setting
   always @* begin
      tick = 1'h0;
      case (clock_source_select)
         `CLOCK_STOPPED: tick = 1'h0;
         3'h1: tick = 1'h1;
         3'h2: tick = ({7'h00, prescaler[2:0]} == `PRESCALE_8);
         3'h3: tick = ({4'h0, prescaler[5:0]} == `PRESCALE_64);
         3'h4: tick = ({2'h0, prescaler[7:0]} == `PRESCALE_256);
         3'h5: tick = (prescaler == `PRESCALE_1024);
         3'h6: tick = pin_prev && !external_count_pin_in;
         3'h7: tick = !pin_prev && external_count_pin_in;
         default: tick = 1'h0;
      endcase
   end
   // ----------------------------------------------------------------
   // shared divider and count pin history
   // ----------------------------------------------------------------
   // one free-running divider serves every tap, so the first divided tick
   // after a source change may come up to one period early
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         prescaler <= 10'h000;
      end else begin
         prescaler <= prescaler + 10'h001;
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         pin_prev <= 1'h0;
      end else begin
         pin_prev <= external_count_pin_in;
      end
   end
   // ----------------------------------------------------------------
   // counter sequence and events
   // ----------------------------------------------------------------
   wire       at_top;
   wire       match_a;
   wire       match_b;
   reg        ovf_event;
   reg  [7:0] next_count;
   reg        next_down;
   assign at_top  = (timer_count_value == top_value);
   assign match_a = tick && !block_match && timer_count_value == compare_value_a;
   assign match_b = tick && !block_match && timer_count_value == compare_value_b;
   always @* begin
      next_count = timer_count_value;
      next_down  = count_down;
      ovf_event  = 1'h0;
      if (tick) begin
         if (phase_mode) begin
            if (!count_down && at_top) begin
               next_down  = 1'h1;
               next_count = timer_count_value - 8'h01;
            end else if (count_down && (timer_count_value == `COUNT_BOTTOM)) begin
               next_down  = 1'h0;
               next_count = 8'h01;
               ovf_event  = 1'h1;
            end else if (count_down) begin
               next_count = timer_count_value - 8'h01;
            end else begin
               next_count = timer_count_value + 8'h01;
            end
         end else begin
            next_down = 1'h0;
            // ctc clears at top but still flags overflow only at max
            if (top_is_a && at_top) begin
               next_count = `COUNT_BOTTOM;
               ovf_event  = (wave_mode_select == `WAVE_FAST_TOP_A);
            end else begin
               next_count = timer_count_value + 8'h01;
            end
            if ((timer_count_value == `COUNT_MAX) && (wave_mode_select != `WAVE_FAST_TOP_A)) begin
               ovf_event = 1'h1;
            end
         end
      end
   end
   // ----------------------------------------------------------------
   // counter registers
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         timer_count_value <= `RESET_BYTE;
      end else if (wr_count) begin
         timer_count_value <= io_wdata_in;
      end else begin
         timer_count_value <= next_count;
      end
   end
   // blocking holds until the first tick after the write
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         block_match <= 1'h0;
      end else if (wr_count) begin
         block_match <= 1'h1;
      end else if (tick) begin
         block_match <= 1'h0;
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         count_down <= 1'h0;
      end else begin
         count_down <= next_down;
      end
   end
   // ----------------------------------------------------------------
   // control, compare and mask registers
   // ----------------------------------------------------------------
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         control_a <= `RESET_BYTE;
      end else if (wr_ctrl_a) begin
         control_a <= io_wdata_in;
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         control_b <= 4'h0;
      end else if (wr_ctrl_b) begin
         control_b <= io_wdata_in[3:0];
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         compare_value_a <= `RESET_BYTE;
      end else if (wr_cmp_a) begin
         compare_value_a <= io_wdata_in;
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         compare_value_b <= `RESET_BYTE;
      end else if (wr_cmp_b) begin
         compare_value_b <= io_wdata_in;
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         timer_interrupt_mask <= 3'h0;
      end else if (wr_mask) begin
         timer_interrupt_mask <= io_wdata_in[2:0];
      end
   end
   // ----------------------------------------------------------------
   // interrupt flags
   // ----------------------------------------------------------------
   reg  [2:0] next_flags;
   // set wins over clear; forced compares never touch the flags
   always @* begin
      next_flags = timer_interrupt_flags;
      next_flags[`BIT_COMPARE_B] = match_b ||
         (timer_interrupt_flags[`BIT_COMPARE_B] && !vector_ack_b_in &&
          !(wr_flags && io_wdata_in[`BIT_COMPARE_B]));
      next_flags[`BIT_COMPARE_A] = match_a ||
         (timer_interrupt_flags[`BIT_COMPARE_A] && !vector_ack_a_in &&
          !(wr_flags && io_wdata_in[`BIT_COMPARE_A]));
      next_flags[`BIT_OVERFLOW] = ovf_event ||
         (timer_interrupt_flags[`BIT_OVERFLOW] && !vector_ack_ovf_in &&
          !(wr_flags && io_wdata_in[`BIT_OVERFLOW]));
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         timer_interrupt_flags <= 3'h0;
      end else begin
         timer_interrupt_flags <= next_flags;
      end
   end
   // ----------------------------------------------------------------
   // waveform outputs
   // ----------------------------------------------------------------
   wire       force_a;
   wire       force_b;
   assign force_a = wr_ctrl_b && io_wdata_in[`BIT_FORCE_A] && non_pwm;
   assign force_b = wr_ctrl_b && io_wdata_in[`BIT_FORCE_B] && non_pwm;
   wire       fast_bottom;
   assign fast_bottom = tick && !phase_mode && !non_pwm && (next_count == `COUNT_BOTTOM);
   function next_pin;
      input       cur;
      input [1:0] mode;
      input       event_hit;
      input       at_bottom;
      input       pwm;
      input       down;
      begin
         next_pin = cur;
         if (!pwm) begin
            if (event_hit) begin
               case (mode)
                  2'h1: next_pin = !cur;
                  2'h2: next_pin = 1'h0;
                  2'h3: next_pin = 1'h1;
                  default: next_pin = cur;
               endcase
            end
         end else if (mode[1]) begin
            if (event_hit) begin
               next_pin = mode[0] ^ down;
            end else if (at_bottom) begin
               next_pin = !mode[0];
            end
         end
      end
   endfunction
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         compare_a_pin_out <= 1'h0;
         compare_b_pin_out <= 1'h0;
      end else begin
         compare_a_pin_out <= next_pin(compare_a_pin_out, compare_a_output_mode,
            match_a || force_a, fast_bottom, !non_pwm, count_down);
         compare_b_pin_out <= next_pin(compare_b_pin_out, compare_b_output_mode,
            match_b || force_b, fast_bottom, !non_pwm, count_down);
      end
   end
   // ----------------------------------------------------------------
   // interrupt requests
   // ----------------------------------------------------------------
   // level requests; the core applies its global enable
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         compare_a_irq_out <= 1'h0;
         compare_b_irq_out <= 1'h0;
         overflow_irq_out  <= 1'h0;
      end else begin
         compare_b_irq_out <= timer_interrupt_flags[`BIT_COMPARE_B] &&
            timer_interrupt_mask[`BIT_COMPARE_B];
         compare_a_irq_out <= timer_interrupt_flags[`BIT_COMPARE_A] &&
            timer_interrupt_mask[`BIT_COMPARE_A];
         overflow_irq_out  <= timer_interrupt_flags[`BIT_OVERFLOW] &&
            timer_interrupt_mask[`BIT_OVERFLOW];
      end
   end
   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   reg  [7:0] next_rdata;
   always @* begin
      next_rdata = io_rdata_out;
      if (io_read_in) begin
         case (io_addr_in)
            `ADDR_TIMER_CONTROL_A: next_rdata = control_a;
            `ADDR_TIMER_CONTROL_B: next_rdata = {4'h0, control_b};
            `ADDR_TIMER_COUNT_VALUE: next_rdata = timer_count_value;
            `ADDR_COMPARE_VALUE_A: next_rdata = compare_value_a;
            `ADDR_COMPARE_VALUE_B: next_rdata = compare_value_b;
            `ADDR_TIMER_INTERRUPT_MASK: next_rdata = {5'h00, timer_interrupt_mask};
            `ADDR_TIMER_INTERRUPT_FLAGS: next_rdata = {5'h00, timer_interrupt_flags};
            default: next_rdata = `RESET_BYTE;
         endcase
      end
   end
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         io_rdata_out <= `RESET_BYTE;
      end else begin
         io_rdata_out <= next_rdata;
      end
   end
endmodule // timer8_control_and_interrupt_regs
`default_nettype wire

// *** tb/timer8_regs_asserts.sv ***
// assertion checker for the 8-bit timer register block
`timescale 1ns/1ps
`default_nettype none
module timer8_regs_checker (
   input wire logic       ref_clk_in,
   input wire logic       rst_in,
   input wire logic [7:0] io_addr_in,
   input wire logic [7:0] io_wdata_in,
   input wire logic       io_write_in,
   input wire logic       io_read_in,
   input wire logic       external_count_pin_in,
   input wire logic       vector_ack_a_in,
   input wire logic       vector_ack_b_in,
   input wire logic       vector_ack_ovf_in,
   input wire logic [7:0] io_rdata_out,
   input wire logic       compare_a_pin_out,
   input wire logic       compare_b_pin_out,
   input wire logic       compare_a_irq_out,
   input wire logic       compare_b_irq_out,
   input wire logic       overflow_irq_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   logic       wl;
   logic [1:0] ma;
   logic [2:0] cs;
   logic [2:0] msk;
   wire        wb = io_write_in && io_addr_in == 8'h45 && io_wdata_in[2:0] == 3'h0 && cs == 3'h0;
   // shadow copies of mode and mask fields, since the checker cannot see inside
   always @(posedge ref_clk_in) begin
      if (rst_in) begin
         {wl, ma, cs, msk} <= 9'h000;
      end else if (io_write_in) begin
         if (io_addr_in == 8'h44) {ma, wl} <= {io_wdata_in[7:6], io_wdata_in[0]};
         if (io_addr_in == 8'h45) cs <= io_wdata_in[2:0];
         if (io_addr_in == 8'h6e) msk <= io_wdata_in[2:0];
      end
   end
   chk_rdata_hold: assert property (!io_read_in |=> $stable(io_rdata_out))
      else $error("read data moved without a read");
   chk_ctlb_read_zero: assert property (io_read_in && io_addr_in == 8'h45 |=>
      io_rdata_out[7:4] == 4'h0) else $error("control b upper bits not zero");
   chk_mask_read_zero: assert property (io_read_in && io_addr_in == 8'h6e |=>
      io_rdata_out[7:3] == 5'h00) else $error("mask reserved bits not zero");
   chk_ovf_mask_off: assert property (io_write_in && io_addr_in == 8'h6e &&
      !io_wdata_in[0] |-> ##2 !overflow_irq_out) else $error("overflow request unmasked");
   chk_stop_hold: assert property (cs == 3'h0 && !io_write_in && !$past(io_write_in) |=>
      $stable({compare_a_pin_out, compare_b_pin_out})) else $error("pins moved while stopped");
   chk_force_pwm_ignored: assert property (wb && wl |=>
      $stable({compare_a_pin_out, compare_b_pin_out}) [*2]) else $error("force acted in pwm");
   chk_force_a_sets: assert property (wb && io_wdata_in[7] && !wl && ma == 2'h3 |->
      ##[1:2] compare_a_pin_out) else $error("forced compare a did not set pin");
   chk_force_no_irq: assert property (wb && io_wdata_in[7:6] == 2'h3 && msk[2:1] == 2'h3 &&
      !compare_a_irq_out && !compare_b_irq_out && !$past(io_write_in) |=>
      !(compare_a_irq_out || compare_b_irq_out) [*2]) else $error("forced compare raised request");
   cover property (overflow_irq_out);
   cover property (compare_a_irq_out);
   cover property (compare_b_pin_out);
endmodule // timer8_regs_checker
bind timer8_control_and_interrupt_regs timer8_regs_checker i_chk (.*);
`default_nettype wire

// *** tb/io_core_model.sv ***
// processor core model issuing single-cycle i/o register accesses
`timescale 1ns/1ps
`default_nettype none
module io_core_model (
   input  wire logic       ref_clk_in,
   input  wire logic [7:0] rdata_in,
   output var  logic [7:0] addr_out,
   output var  logic [7:0] wdata_out,
   output var  logic       write_out,
   output var  logic       read_out
);
   initial {addr_out, wdata_out, write_out, read_out} = 18'h00000;
   // strobe stands for exactly one edge, where the block takes it
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      addr_out <= a;
      wdata_out <= d;
      write_out <= 1'h1;
      @(posedge ref_clk_in);
      write_out <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      addr_out <= a;
      read_out <= 1'h1;
      @(posedge ref_clk_in);
      read_out <= 1'h0;
      @(posedge ref_clk_in);
      d = rdata_in;
   endtask
endmodule // io_core_model
`default_nettype wire

// *** tb/timer8_control_and_interrupt_regs_tb_top.sv ***
// self-checking testbench of the 8-bit timer register block
`timescale 1ns/1ps
`default_nettype none
module timer8_control_and_interrupt_regs_tb_top;
   logic       ref_clk_in = 1'h0;
   logic       rst_in = 1'h1;
   logic       pin = 1'h0;
   logic [2:0] ack = 3'h0;
   logic [7:0] a, wd, rdat, r;
   logic       we, re, pa, pb, ia, ib, io;
   int         miscompares = 0;
   int         checks_done = 0;
   always #20 ref_clk_in = ~ref_clk_in;
   io_core_model i_core (.ref_clk_in(ref_clk_in), .rdata_in(rdat), .addr_out(a),
      .wdata_out(wd), .write_out(we), .read_out(re));
   timer8_control_and_interrupt_regs i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
      .io_addr_in(a), .io_wdata_in(wd), .io_write_in(we), .io_read_in(re),
      .external_count_pin_in(pin), .vector_ack_a_in(ack[0]), .vector_ack_b_in(ack[1]),
      .vector_ack_ovf_in(ack[2]), .io_rdata_out(rdat), .compare_a_pin_out(pa),
      .compare_b_pin_out(pb), .compare_a_irq_out(ia), .compare_b_irq_out(ib),
      .overflow_irq_out(io));
   task chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
      checks_done++;
      if (((got >= lo) && (got <= hi)) !== 1'h1) begin
         miscompares++;
         $display("[ERR] %0t got %h want %h..%h", $time, got, lo, hi);
      end
   endtask
   task w(input logic [7:0] ad, input logic [7:0] d);
      i_core.wr(ad, d);
   endtask
   task rchk(input logic [7:0] ad, input logic [7:0] v, input logic [7:0] hi);
      i_core.rd(ad, r);
      chk(r, v, hi);
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task t_regs;
      rchk(8'h45, 8'h00, 8'h00);
      rchk(8'h48, 8'h00, 8'h00);
      w(8'h6e, 8'hff);
      rchk(8'h6e, 8'h07, 8'h07);
      w(8'h45, 8'hf8);
      rchk(8'h45, 8'h08, 8'h08);
      w(8'h45, 8'h00);
      w(8'h47, 8'h80);
      w(8'h46, 8'h5a);
      rchk(8'h46, 8'h5a, 8'h5a);
      rchk(8'h10, 8'h00, 8'h00);
      $display("t_regs done");
   endtask
   task t_ovf;
      w(8'h46, 8'hfd);
      w(8'h45, 8'h01);
      repeat (8) @(posedge ref_clk_in);
      w(8'h45, 8'h00);
      chk({7'h00, io}, 8'h01, 8'h01);
      rchk(8'h35, 8'h05, 8'h05);
      w(8'h6e, 8'h00);
      repeat (2) @(posedge ref_clk_in);
      chk({7'h00, io}, 8'h00, 8'h00);
      w(8'h6e, 8'h07);
      ack <= 3'h4;
      @(posedge ref_clk_in);
      ack <= 3'h0;
      rchk(8'h35, 8'h04, 8'h04);
      w(8'h35, 8'h04);
      rchk(8'h35, 8'h00, 8'h00);
      $display("t_ovf done");
   endtask
   task t_cmpa;
      w(8'h46, 8'h10);
      w(8'h47, 8'h12);
      w(8'h45, 8'h01);
      repeat (8) @(posedge ref_clk_in);
      w(8'h45, 8'h00);
      chk({6'h00, ia, ib}, 8'h02, 8'h02);
      ack <= 3'h1;
      @(posedge ref_clk_in);
      ack <= 3'h0;
      rchk(8'h35, 8'h00, 8'h00);
      $display("t_cmpa done");
   endtask
   task t_block;
      w(8'h48, 8'h30);
      w(8'h46, 8'h30);
      w(8'h45, 8'h01);
      repeat (4) @(posedge ref_clk_in);
      w(8'h45, 8'h00);
      rchk(8'h35, 8'h00, 8'h00);
      w(8'h46, 8'h2e);
      w(8'h45, 8'h01);
      repeat (4) @(posedge ref_clk_in);
      w(8'h45, 8'h00);
      rchk(8'h35, 8'h04, 8'h04);
      ack <= 3'h2;
      @(posedge ref_clk_in);
      ack <= 3'h0;
      rchk(8'h35, 8'h00, 8'h00);
      $display("t_block done");
   endtask
   task t_ext;
      for (int c = 6; c < 8; c++) begin
         w(8'h46, 8'h00);
         w(8'h45, 8'(c));
         repeat (3) begin
            pin <= 1'h1;
            repeat (2) @(posedge ref_clk_in);
            pin <= 1'h0;
            repeat (2) @(posedge ref_clk_in);
         end
         w(8'h45, 8'h00);
         rchk(8'h46, 8'h03, 8'h03);
      end
      $display("t_ext done");
   endtask
   task t_pre;
      int dv[5] = '{1, 8, 64, 256, 1024};
      for (int c = 1; c < 6; c++) begin
         w(8'h46, 8'h00);
         w(8'h45, 8'(c));
         repeat (8 * dv[c - 1]) @(posedge ref_clk_in);
         w(8'h45, 8'h00);
         rchk(8'h46, 8'h08, (c == 1) ? 8'h0b : 8'h09);
      end
      $display("t_pre done");
   endtask
   task t_top;
      for (int m = 0; m < 2; m++) begin
         w(8'h35, 8'h07);
         w(8'h44, (m == 0) ? 8'h02 : 8'h03);
         w(8'h47, 8'h05);
         w(8'h46, 8'h00);
         w(8'h45, (m == 0) ? 8'h01 : 8'h09);
         repeat (8) @(posedge ref_clk_in);
         w(8'h45, 8'h00);
         rchk(8'h46, 8'h04, 8'h04);
         rchk(8'h35, (m == 0) ? 8'h02 : 8'h03, (m == 0) ? 8'h02 : 8'h03);
      end
      $display("t_top done");
   endtask
   task t_force;
      w(8'h35, 8'h07);
      w(8'h44, 8'hf1);
      w(8'h45, 8'hc0); // strobes in pwm on purpose, to see them ignored
      repeat (2) @(posedge ref_clk_in);
      chk({6'h00, pa, pb}, 8'h00, 8'h00);
      w(8'h45, 8'h00);
      w(8'h44, 8'hf0);
      w(8'h45, 8'hc0);
      repeat (2) @(posedge ref_clk_in);
      chk({6'h00, pa, pb}, 8'h03, 8'h03);
      rchk(8'h35, 8'h00, 8'h00);
      $display("t_force done");
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge ref_clk_in);
      rst_in <= 1'h0;
      t_regs;
      t_ovf;
      t_cmpa;
      t_block;
      t_ext;
      t_pre;
      t_top;
      t_force;
      conclude;
   end
   // the prescaler sweep dominates, about 11k cycles
   initial begin
      repeat (40000) @(posedge ref_clk_in);
      miscompares++;
      conclude;
   end
endmodule // timer8_control_and_interrupt_regs_tb_top
`default_nettype wire
